// >>> rtl/npos_params.svh
// Constants for the NAND page operation host sequencer.
`ifndef NPOS_PARAMS_SVH
`define NPOS_PARAMS_SVH
`define NPOS_CMD_READ_SETUP 8'h00
`define NPOS_CMD_READ_CONFIRM 8'h30
`define NPOS_CMD_COL_OUT 8'h05
`define NPOS_CMD_COL_OUT_CONFIRM 8'hE0
`define NPOS_CMD_CACHE_READ 8'h31
`define NPOS_CMD_CACHE_READ_LAST 8'h3F
`define NPOS_CMD_MULTI_READ_SETUP 8'h60
`define NPOS_CMD_DATA_IN 8'h80
`define NPOS_CMD_MULTI_DATA_IN 8'h81
`define NPOS_CMD_COL_IN 8'h85
`define NPOS_CMD_PROGRAM 8'h10
`define NPOS_CMD_MULTI_PROGRAM 8'h11
`define NPOS_CMD_CACHE_PROGRAM 8'h15
`define NPOS_CMD_STATUS 8'h70
`define NPOS_CMD_RESET 8'hFF
`define NPOS_STATUS_FAIL_BIT 0
`define NPOS_STROBE_NS 20
`define NPOS_CLK_NS 10
`define NPOS_STROBE_CYC ((`NPOS_STROBE_NS + `NPOS_CLK_NS - 1) / `NPOS_CLK_NS)
`define NPOS_FIFO_DEPTH 8
`endif

// >>> rtl/npos_pkg.sv
// Types for the NAND page operation host sequencer.
package npos_pkg;
  typedef enum logic [3:0] {
    NPOS_OP_READ,
    NPOS_OP_READ_COL,
    NPOS_OP_CACHE_READ,
    NPOS_OP_CACHE_READ_LAST,
    NPOS_OP_MULTI_READ,
    NPOS_OP_PROGRAM,
    NPOS_OP_PROGRAM_COL,
    NPOS_OP_CACHE_PROGRAM,
    NPOS_OP_MULTI_PROGRAM,
    NPOS_OP_STATUS
  } npos_op_e;
  typedef struct packed {
    npos_op_e op;
    logic [12:0] column;
    logic [17:0] row;
    logic [17:0] row2;
    logic [12:0] count;
  } npos_req_s;
  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
    logic wp_n;
  } npos_pins_s;
  typedef logic [7:0] npos_byte_t;
endpackage : npos_pkg

// >>> rtl/npos_fifo.sv
// Parameterised valid/ready FIFO used in the data path.
`timescale 1ns/1ps
module npos_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] fill, next_fill;
  logic push, pop, ready_q;
  always_comb begin
    push = i_valid && ready_q;
    pop = i_ready && (fill != '0);
    next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
    next_fill = fill + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
      ready_q <= 1'b1;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill <= next_fill;
      ready_q <= (next_fill != (AW+1)'(DEPTH));
    end
  end
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end
  // Ready is a flag of its own so that the writer sees a flip-flop output.
  assign o_ready = ready_q;
  assign o_valid = (fill != '0);
  assign o_data = mem[rd_ptr];
endmodule : npos_fifo

// >>> rtl/npos_host.sv
// Host controller that sequences page operations on a NAND flash.
// Function
// - Read is 00h, five address cycles, then 30h confirm.
// - Host strobes data out from the addressed column after ready.
// - Column change in output: 05h, two column cycles, E0h.
// - Host issues cache read as 31h or 3Fh alone, with no address cycles.
// - Multi read: 60h plus address per district, then 30h.
// - At most one block per district; order free.
// - Write protect held high throughout multi page read.
// - Program: 80h, address, data, then 10h.
// - Column change in input: 85h, two column cycles.
// - Between 11h and 81h only 70h or FFh are issued.
// - Cache program ends with 15h; ready means all done.
// - Address is two column cycles and three row cycles.
`timescale 1ns/1ps
`include "npos_params.svh"
module npos_host (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire npos_pkg::npos_req_s I_REQ,
  input wire logic I_REQ_VALID,
  output logic O_REQ_READY,
  input wire npos_pkg::npos_byte_t I_WDATA,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output npos_pkg::npos_byte_t O_RDATA,
  output logic O_RVALID,
  output logic O_FAIL,
  output npos_pkg::npos_pins_s O_PINS,
  output npos_pkg::npos_byte_t O_IO,
  output logic O_IO_OE,
  input wire npos_pkg::npos_byte_t I_IO,
  input wire logic I_READY_BUSY_N
);
  import npos_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_WAIT_BUSY, ST_WAIT_READY,
    ST_RDATA
  } npos_state_e;
  localparam logic [3:0] STROBE_CYC = 4'(`NPOS_STROBE_CYC);
  npos_state_e state, next_state;
  npos_req_s req, next_req;
  npos_pins_s pins, next_pins;
  npos_byte_t io, next_io, rdata, next_rdata;
  logic io_oe, next_io_oe, rvalid, next_rvalid, fail, next_fail;
  logic req_ready, next_req_ready;
  logic [3:0] tick, next_tick;
  logic [3:0] step, next_step;
  logic [2:0] acyc, next_acyc, alen, next_alen;
  logic [12:0] left, next_left;
  logic [2:0] rb_sync;
  logic rb;
  logic phase, next_phase;
  logic wd_valid, wd_pop;
  npos_byte_t wd_byte;
  // Write data is staged so the caller is not stalled while the bus is busy.
  npos_fifo #(.WIDTH(8), .DEPTH(`NPOS_FIFO_DEPTH)) u_wfifo (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_data(I_WDATA),
    .i_valid(I_WVALID),
    .o_ready(O_WREADY),
    .o_data(wd_byte),
    .o_valid(wd_valid),
    .i_ready(wd_pop)
  );
  // Busy line crosses from the pin; change counts when stages 2 and 3 agree.
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rb_sync <= 3'h7;
      rb <= 1'b1;
    end else begin
      rb_sync <= {rb_sync[1:0], I_READY_BUSY_N};
      if (rb_sync[1] == rb_sync[2]) begin
        rb <= rb_sync[2];
      end
    end
  end
  // Command byte for a given step of each operation.
  function automatic npos_byte_t cmd_of(input npos_op_e op,
                                        input logic [3:0] st);
    case (op)
      NPOS_OP_READ: cmd_of = st == 0 ? `NPOS_CMD_READ_SETUP
                                     : `NPOS_CMD_READ_CONFIRM;
      NPOS_OP_READ_COL: cmd_of = st == 0 ? `NPOS_CMD_COL_OUT
                                         : `NPOS_CMD_COL_OUT_CONFIRM;
      NPOS_OP_CACHE_READ: cmd_of = `NPOS_CMD_CACHE_READ;
      NPOS_OP_CACHE_READ_LAST: cmd_of = `NPOS_CMD_CACHE_READ_LAST;
      NPOS_OP_MULTI_READ: cmd_of = st == 2 ? `NPOS_CMD_READ_CONFIRM
                                   : `NPOS_CMD_MULTI_READ_SETUP;
      NPOS_OP_PROGRAM: cmd_of = st == 0 ? `NPOS_CMD_DATA_IN
                                        : `NPOS_CMD_PROGRAM;
      NPOS_OP_PROGRAM_COL: cmd_of = `NPOS_CMD_COL_IN;
      NPOS_OP_CACHE_PROGRAM: cmd_of = st == 0 ? `NPOS_CMD_DATA_IN
                                     : `NPOS_CMD_CACHE_PROGRAM;
      NPOS_OP_MULTI_PROGRAM: begin
        case (st)
          4'h0: cmd_of = `NPOS_CMD_DATA_IN;
          4'h1: cmd_of = `NPOS_CMD_MULTI_PROGRAM;
          4'h2: cmd_of = `NPOS_CMD_MULTI_DATA_IN;
          4'h3: cmd_of = `NPOS_CMD_PROGRAM;
          default: cmd_of = `NPOS_CMD_STATUS;
        endcase
      end
      default: cmd_of = `NPOS_CMD_STATUS;
    endcase
  endfunction : cmd_of
  // Address byte n from column and row.
  function automatic npos_byte_t addr_of(input logic [12:0] col,
                                         input logic [17:0] row,
                                         input logic [2:0] n);
    case (n)
      3'h0: addr_of = col[7:0];
      3'h1: addr_of = {3'h0, col[12:8]};
      3'h2: addr_of = row[7:0];
      3'h3: addr_of = row[15:8];
      default: addr_of = {6'h00, row[17:16]};
    endcase
  endfunction : addr_of
  always_comb begin
    next_state = state;
    next_req = req;
    next_pins = pins;
    next_io = io;
    next_io_oe = io_oe;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_fail = fail;
    next_req_ready = 1'b0;
    next_tick = tick;
    next_step = step;
    next_acyc = acyc;
    next_alen = alen;
    next_left = left;
    next_phase = phase;
    wd_pop = 1'b0;
    case (state)
      ST_IDLE: begin
        next_pins = '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                      re_n: 1'b1, wp_n: 1'b1};
        next_io_oe = 1'b0;
        // Ready must not wait for valid, or a held request would never go.
        next_req_ready = !(I_REQ_VALID && req_ready);
        if (I_REQ_VALID && req_ready) begin
          next_req = I_REQ;
          next_step = 4'h0;
          next_pins.ce_n = 1'b0;
          next_state = ST_CMD;
        end
      end
      ST_CMD: begin
        // Strobe low for one half, high for the other; latch on rise.
        next_pins.cle = 1'b1;
        next_pins.ale = 1'b0;
        next_io = cmd_of(req.op, step);
        next_io_oe = 1'b1;
        next_tick = tick + 4'h1;
        next_pins.we_n = phase;
        if (tick == STROBE_CYC) begin
          next_tick = 4'h0;
          next_phase = !phase;
          if (phase) begin
            next_pins.cle = 1'b0;
            next_acyc = 3'h0;
            next_left = req.count;
            case (req.op)
              NPOS_OP_READ, NPOS_OP_MULTI_READ, NPOS_OP_PROGRAM,
              NPOS_OP_CACHE_PROGRAM, NPOS_OP_MULTI_PROGRAM: begin
                if (req.op == NPOS_OP_MULTI_READ ? step != 4'h2
                    : step[0] == 1'b0) begin
                  next_alen = req.op == NPOS_OP_MULTI_READ ? 3'h3 : 3'h5;
                  next_acyc = req.op == NPOS_OP_MULTI_READ ? 3'h2 : 3'h0;
                  next_state = ST_ADDR;
                end else begin
                  next_state = ST_WAIT_BUSY;
                end
              end
              NPOS_OP_READ_COL, NPOS_OP_PROGRAM_COL: begin
                if (step == 4'h0) begin
                  next_alen = 3'h2;
                  next_state = ST_ADDR;
                end else begin
                  next_state = ST_RDATA;
                end
              end
              NPOS_OP_STATUS: begin
                next_left = 13'h0001;
                next_state = ST_RDATA;
              end
              default: next_state = ST_WAIT_BUSY;
            endcase
            next_step = step + 4'h1;
          end
        end
      end
      ST_ADDR: begin
        next_pins.ale = 1'b1;
        next_io = addr_of(req.column,
                          step >= 4'h2 ? req.row2 : req.row, acyc);
        next_tick = tick + 4'h1;
        next_pins.we_n = phase;
        if (tick == STROBE_CYC) begin
          next_tick = 4'h0;
          next_phase = !phase;
          if (phase) begin
            next_acyc = acyc + 3'h1;
            if (acyc + 3'h1 == (req.op == NPOS_OP_MULTI_READ ? 3'h5
                                : alen)) begin
              next_pins.ale = 1'b0;
              if (req.op == NPOS_OP_READ_COL || req.op == NPOS_OP_READ ||
                  req.op == NPOS_OP_MULTI_READ) begin
                next_state = ST_CMD;
              end else if (left != 13'h0000) begin
                next_state = ST_WDATA;
              end else begin
                next_state = req.op == NPOS_OP_PROGRAM_COL ? ST_IDLE : ST_CMD;
              end
            end
          end
        end
      end
      ST_WDATA: begin
        next_io = wd_byte;
        if (!phase && tick == 4'h0 && !wd_valid) begin
          next_tick = 4'h0;
        end else begin
          next_tick = tick + 4'h1;
          next_pins.we_n = phase;
          if (tick == STROBE_CYC) begin
            next_tick = 4'h0;
            next_phase = !phase;
            if (phase) begin
              wd_pop = 1'b1;
              next_left = left - 13'h0001;
              if (left == 13'h0001) begin
                next_state = req.op == NPOS_OP_PROGRAM_COL ? ST_IDLE
                                                           : ST_CMD;
              end
            end
          end
        end
      end
      ST_WAIT_BUSY: begin
        next_io_oe = 1'b0;
        next_tick = tick + 4'h1;
        if (!rb || tick == 4'hF) begin
          next_tick = 4'h0;
          next_state = ST_WAIT_READY;
        end
      end
      ST_WAIT_READY: begin
        if (rb) begin
          if (req.op == NPOS_OP_MULTI_PROGRAM && step == 4'h2) begin
            next_state = ST_CMD;
          end else if (req.op == NPOS_OP_PROGRAM ||
                       req.op == NPOS_OP_CACHE_PROGRAM ||
                       req.op == NPOS_OP_MULTI_PROGRAM) begin
            next_req.op = NPOS_OP_STATUS;
            next_step = 4'h0;
            next_state = ST_CMD;
          end else begin
            next_left = req.count;
            next_state = left == 13'h0 ? ST_IDLE : ST_RDATA;
          end
        end
      end
      ST_RDATA: begin
        next_io_oe = 1'b0;
        next_tick = tick + 4'h1;
        next_pins.re_n = phase;
        if (tick == STROBE_CYC) begin
          next_tick = 4'h0;
          next_phase = !phase;
          if (!phase) begin
            next_rdata = I_IO;
            next_rvalid = 1'b1;
            if (req.op == NPOS_OP_STATUS) begin
              next_fail = I_IO[`NPOS_STATUS_FAIL_BIT];
            end
          end else begin
            next_left = left - 13'h0001;
            if (left <= 13'h0001) begin
              next_state = ST_IDLE;
            end
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state <= ST_IDLE;
      req <= '0;
      pins <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1,
                wp_n: 1'b0};
      io <= 8'h00;
      io_oe <= 1'b0;
      rdata <= 8'h00;
      rvalid <= 1'b0;
      fail <= 1'b0;
      req_ready <= 1'b0;
      tick <= 4'h0;
      step <= 4'h0;
      acyc <= 3'h0;
      alen <= 3'h0;
      left <= 13'h0000;
      phase <= 1'b0;
    end else begin
      state <= next_state;
      req <= next_req;
      pins <= next_pins;
      io <= next_io;
      io_oe <= next_io_oe;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      fail <= next_fail;
      req_ready <= next_req_ready;
      tick <= next_tick;
      step <= next_step;
      acyc <= next_acyc;
      alen <= next_alen;
      left <= next_left;
      phase <= next_phase;
    end
  end
  assign O_REQ_READY = req_ready;
  assign O_RDATA = rdata;
  assign O_RVALID = rvalid;
  assign O_FAIL = fail;
  assign O_PINS = pins;
  assign O_IO = io;
  assign O_IO_OE = io_oe;
endmodule : npos_host

// >>> testbench/npos_host_properties.sv
// Concurrent checks on the ports of the NAND page operation host sequencer.
`timescale 1ns/1ps
module npos_host_properties (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_REQ_VALID,
  input wire logic O_REQ_READY,
  input wire logic O_RVALID,
  input wire npos_pkg::npos_pins_s O_PINS,
  input wire logic O_IO_OE,
  input wire logic I_READY_BUSY_N
);
  import npos_pkg::*;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  a_req_opens_cmd: assert property (
    I_REQ_VALID && O_REQ_READY |=>
      !O_PINS.ce_n && !O_REQ_READY ##1 O_PINS.cle)
    else $error("request did not open a command cycle");
  a_latch_driven: assert property (
    !O_PINS.we_n && (O_PINS.cle || O_PINS.ale) |-> O_IO_OE && !O_PINS.ce_n)
    else $error("latch strobe without driven bus");
  a_cmd_addr_excl: assert property (
    !(O_PINS.cle && O_PINS.ale))
    else $error("command and address latch both high");
  a_we_low_width: assert property (
    $fell(O_PINS.we_n) |=> !O_PINS.we_n [*2])
    else $error("write strobe low half too short");
  a_re_strobe_shape: assert property (
    $fell(O_PINS.re_n) |=> !O_PINS.re_n [*2] ##1 O_PINS.re_n)
    else $error("read strobe low half wrong length");
  a_no_drive_read: assert property (
    O_IO_OE |-> O_PINS.re_n)
    else $error("bus driven while reading");
  a_busy_quiet: assert property (
    !I_READY_BUSY_N [*4] |-> O_PINS.we_n && O_PINS.re_n)
    else $error("strobe while device busy");
  a_rvalid_gap: assert property (
    O_RVALID |=> !O_RVALID [*4])
    else $error("read bytes closer than one strobe");
  a_wp_high: assert property (
    $past(I_RST_N) |-> O_PINS.wp_n)
    else $error("write protect low out of reset");
endmodule : npos_host_properties
bind npos_host npos_host_properties chk_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_REQ_VALID(I_REQ_VALID), .O_REQ_READY(O_REQ_READY),
  .O_RVALID(O_RVALID), .O_PINS(O_PINS), .O_IO_OE(O_IO_OE),
  .I_READY_BUSY_N(I_READY_BUSY_N));

// >>> testbench/npos_flash_model.sv
// Behavioural NAND flash device facing the host sequencer.
`timescale 1ns/1ps
module npos_flash_model (
  input wire logic i_clk,
  input wire npos_pkg::npos_pins_s i_pins,
  input wire npos_pkg::npos_byte_t i_io,
  input wire logic i_io_oe,
  input wire logic [7:0] i_busy_len,
  input wire logic i_fail,
  output npos_pkg::npos_byte_t o_io,
  output logic o_ready_busy_n,
  output npos_pkg::npos_byte_t o_last_wr,
  output logic [7:0] o_wr_cnt
);
  import npos_pkg::*;
  npos_byte_t dout = 8'h00;
  logic [2:0] acnt = 3'h0;
  logic [12:0] col = 13'h0000;
  logic [7:0] bcnt = 8'h00;
  logic we_q = 1'b1;
  logic re_q = 1'b1;
  logic stat = 1'b0;
  npos_byte_t wr_last = 8'h00;
  logic [7:0] wr_cnt = 8'h00;
  always @(posedge i_clk) begin
    we_q <= i_pins.we_n;
    re_q <= i_pins.re_n;
    if (bcnt != 8'h00) bcnt <= bcnt - 8'h01;
    if (!we_q && i_pins.we_n && !i_pins.ce_n && i_pins.cle) begin
      stat <= (i_io == 8'h70);
      acnt <= (i_io == 8'h60) ? 3'h2 : 3'h0;
      if (i_io inside {8'h30, 8'h31, 8'h3F, 8'h10, 8'h11, 8'h15})
        bcnt <= i_busy_len;
    end else if (!we_q && i_pins.we_n && !i_pins.ce_n && i_pins.ale) begin
      // Addresses are taken in any mode, so a read needs no setup command.
      if (acnt == 3'h0) col[7:0] <= i_io;
      if (acnt == 3'h1) col[12:8] <= i_io[4:0];
      acnt <= acnt + 3'h1;
    end else if (!we_q && i_pins.we_n && !i_pins.ce_n) begin
      wr_last <= i_io;
      wr_cnt <= wr_cnt + 8'h01;
    end
    if (re_q && !i_pins.re_n) begin
      dout <= stat ? {7'h70, i_fail} : col[7:0];
      col <= col + 13'h0001;
    end
  end
  assign o_ready_busy_n = (bcnt == 8'h00);
  assign o_last_wr = wr_last;
  assign o_wr_cnt = wr_cnt;
  // A released bus shows the inverse so stale data cannot pass as valid.
  assign o_io = i_io_oe ? i_io : (!i_pins.re_n && !i_pins.ce_n) ? dout : ~dout;
endmodule : npos_flash_model

// >>> testbench/tb.sv
// Self-checking bench for the NAND page operation host sequencer.
`timescale 1ns/1ps
module tb;
  import npos_pkg::*;
  logic I_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  npos_req_s req = '0;
  logic req_valid = 1'b0;
  npos_byte_t wdata = 8'h00;
  logic wvalid = 1'b0;
  logic [7:0] busy_len = 8'h06;
  logic fail = 1'b0;
  logic req_ready, rvalid, o_fail, io_oe, wready, rb_n;
  npos_byte_t rdata, io_out, io_wire;
  npos_pins_s pins;
  npos_byte_t last_wr;
  logic [7:0] wr_cnt;
  npos_byte_t rx_q[$];
  int err_total = 0;
  int n_compared = 0;
  initial forever #5 I_CLK = ~I_CLK;
  npos_host dut_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REQ(req),
    .I_REQ_VALID(req_valid), .O_REQ_READY(req_ready), .I_WDATA(wdata),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_RDATA(rdata),
    .O_RVALID(rvalid), .O_FAIL(o_fail), .O_PINS(pins), .O_IO(io_out),
    .O_IO_OE(io_oe), .I_IO(io_wire), .I_READY_BUSY_N(rb_n));
  npos_flash_model dev_u (.i_clk(I_CLK), .i_pins(pins), .i_io(io_out),
    .i_io_oe(io_oe), .i_busy_len(busy_len), .i_fail(fail), .o_io(io_wire),
    .o_ready_busy_n(rb_n), .o_last_wr(last_wr), .o_wr_cnt(wr_cnt));
  always @(negedge I_CLK) if (rvalid === 1'b1) rx_q.push_back(rdata);
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic check(input npos_byte_t got, input npos_byte_t exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic push(input int n);
    int i;
    logic ok;
    i = 0;
    wvalid = 1'b1;
    for (int t = 0; t < 200 && i < n; t++) begin
      wdata = 8'hA0 + 8'(i);
      ok = (wready === 1'b1);
      @(negedge I_CLK);
      if (ok) i++;
    end
    wvalid = 1'b0;
  endtask : push
  task automatic run_op(input npos_op_e op, input logic [12:0] col,
                        input logic [12:0] cnt);
    int t;
    rx_q.delete();
    req.op = op;
    req.column = col;
    req.row = 18'h00041;
    req.row2 = 18'h00081;
    req.count = cnt;
    req_valid = 1'b1;
    for (t = 0; t < 500 && req_ready !== 1'b1; t++) @(negedge I_CLK);
    @(negedge I_CLK);
    req_valid = 1'b0;
    check(8'(req_ready), 8'h00);
    for (t = 0; t < 5000 && req_ready !== 1'b1; t++) @(negedge I_CLK);
    check(8'(req_ready), 8'h01);
  endtask : run_op
  task automatic t_read();
    run_op(NPOS_OP_READ, 13'h11FE, 13'h0004);
    check(8'(rx_q.size()), 8'h04);
    foreach (rx_q[i]) check(rx_q[i], 8'hFE + 8'(i));
  endtask : t_read
  task automatic t_col();
    logic [12:0] cols[2] = '{13'h0A30, 13'h0005};
    foreach (cols[k]) begin
      run_op(NPOS_OP_READ_COL, cols[k], 13'h0003);
      check(8'(rx_q.size()), 8'h03);
      foreach (rx_q[i]) check(rx_q[i], cols[k][7:0] + 8'(i));
    end
  endtask : t_col
  task automatic t_cache();
    run_op(NPOS_OP_CACHE_READ, 13'h0000, 13'h0003);
    check(8'(rx_q.size()), 8'h03);
    run_op(NPOS_OP_CACHE_READ_LAST, 13'h0000, 13'h0003);
    check(8'(rx_q.size()), 8'h03);
  endtask : t_cache
  task automatic t_multi();
    busy_len = 8'h28;
    run_op(NPOS_OP_MULTI_READ, 13'h0000, 13'h0002);
    check(8'(rx_q.size()), 8'h02);
  endtask : t_multi
  task automatic t_fifo();
    logic [7:0] base;
    push(8);
    check(8'(wready), 8'h00);
    base = wr_cnt;
    run_op(NPOS_OP_PROGRAM_COL, 13'h0020, 13'h0008);
    check(8'(wready), 8'h01);
    check(wr_cnt - base, 8'h08);
    check(last_wr, 8'hA7);
  endtask : t_fifo
  task automatic t_prog();
    npos_op_e ops[4] = '{NPOS_OP_CACHE_PROGRAM, NPOS_OP_CACHE_PROGRAM,
                         NPOS_OP_PROGRAM, NPOS_OP_MULTI_PROGRAM};
    foreach (ops[k]) begin
      fail = k[0];
      push(ops[k] == NPOS_OP_MULTI_PROGRAM ? 6 : 3);
      run_op(ops[k], 13'h0010, 13'h0003);
      check(8'(o_fail), 8'(k[0]));
      check(last_wr, ops[k] == NPOS_OP_MULTI_PROGRAM ? 8'hA5 : 8'hA2);
    end
  endtask : t_prog
  initial begin
    repeat (12) @(negedge I_CLK);
    I_RST_N = 1'b1;
    repeat (2) @(negedge I_CLK);
    t_read();
    t_col();
    t_cache();
    t_multi();
    t_fifo();
    t_prog();
    summarize();
  end
  // The tests need about a thousand cycles; forty thousand means a hang.
  initial begin
    #400000;
    err_total++;
    summarize();
  end
endmodule : tb
